// ===== src/sis_pkg.sv
// Constants and types for the identification and status register group.
// Assumes a bus framer in the device that decodes register reads by address.
package sis_pkg;

    localparam int          SIS_ADDR_W          = 6;
    localparam int          SIS_DATA_W          = 16;
    localparam logic [5:0]  SIS_ADDR_MAKER      = 6'o01;
    localparam logic [5:0]  SIS_ADDR_PART       = 6'o02;
    localparam logic [5:0]  SIS_ADDR_CAPS       = 6'o03;
    localparam logic [5:0]  SIS_ADDR_STATUS     = 6'o04;
    localparam logic [5:0]  SIS_ADDR_READOUT    = 6'o11;
    localparam int          SIS_PART_LSB        = 0;
    localparam int          SIS_PART_W          = 11;
    localparam int          SIS_REV_LSB         = 11;
    localparam int          SIS_REV_W           = 5;
    localparam int          SIS_ST_EVENT_BIT    = 0;
    localparam int          SIS_ST_ERROR_BIT    = 4;
    localparam int          SIS_ST_BUS_BIT      = 7;
    localparam logic [15:0] SIS_CAPS_VALUE      = 16'h0001;
    localparam logic [7:0]  SIS_STATUS_RESET    = 8'h00;
    localparam logic [15:0] SIS_DATA_RESET      = 16'h0000;

    // Events arriving from the temperature function and the bus framer.
    typedef struct packed {
        logic result_stored;
        logic func_error;
        logic func_handled;
        logic nack_seen;
    } sis_events_t;

    // One register read request from the bus framer.
    typedef struct packed {
        logic       strobe;
        logic [5:0] addr;
    } sis_read_t;

endpackage : sis_pkg

// ===== src/sis_flag.sv
// Sticky flag with set, clear and synchronous reset; set wins over clear.
// Assumes all inputs come from logic on clk_in.
`timescale 1ns/1ps
module sis_flag
    import sis_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_out
);
    logic flag_q;
    logic flag_d;

    always_comb
    begin
        flag_d = flag_q;
        if (clr_in)
        begin
            flag_d = 1'b0;
        end
        if (set_in)
        begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;

endmodule : sis_flag

// ===== src/sis_regs.sv
// Read-only identification, capability and status registers.
// Assumes a bus framer that issues one-cycle read strobes with an address,
// reports no-acknowledge events, and pulses device reset on the reset input.
`timescale 1ns/1ps
module sis_regs
    import sis_pkg::*;
#(
    // Arbitrary neutral identity values.
    parameter logic [15:0] MAKER_CODE = 16'h0A5A,
    parameter logic [10:0] PART_CODE  = 11'h005,
    parameter logic [4:0]  DIE_REV    = 5'h00
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire sis_read_t   rd_in,
    input  wire sis_events_t ev_in,
    output logic [15:0]      rd_data_out,
    output logic             rd_valid_out,
    output logic [7:0]       status_out
);
    logic        rd_status;
    logic        rd_readout;
    logic        unread_q;
    logic        unread_d;
    logic        overrun;
    logic        ev_flag;
    logic        err_flag;
    logic        bus_flag;
    logic [7:0]  status_now;
    logic [15:0] data_q;
    logic [15:0] data_d;
    logic        valid_q;
    logic        valid_d;
    logic [7:0]  status_q;

    // Part code and die revision must fill one read word exactly.
    if (SIS_PART_W + SIS_REV_W != SIS_DATA_W)
    begin : g_field_check
        $error("part and revision fields do not fill a data word");
    end

    assign rd_status  = rd_in.strobe && rd_in.addr == SIS_ADDR_STATUS;
    assign rd_readout = rd_in.strobe && rd_in.addr == SIS_ADDR_READOUT;
    assign overrun    = ev_in.result_stored && unread_q && !rd_readout;

    always_comb
    begin
        unread_d = unread_q;
        if (rd_readout)
        begin
            unread_d = 1'b0;
        end
        if (ev_in.result_stored)
        begin
            unread_d = 1'b1;
        end
    end

    // Reset of every flag comes from rst_n_in, the device reset.
    sis_flag u_event_flag (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .set_in   (ev_in.result_stored),
        .clr_in   (ev_in.func_handled || rd_readout),
        .flag_out (ev_flag)
    );

    sis_flag u_error_flag (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .set_in   (ev_in.func_error || overrun),
        .clr_in   (ev_in.func_handled || rd_readout),
        .flag_out (err_flag)
    );

    sis_flag u_bus_flag (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .set_in   (ev_in.nack_seen),
        .clr_in   (rd_status),
        .flag_out (bus_flag)
    );

    always_comb
    begin
        status_now = SIS_STATUS_RESET;
        status_now[SIS_ST_EVENT_BIT] = ev_flag;
        status_now[SIS_ST_ERROR_BIT] = err_flag;
        status_now[SIS_ST_BUS_BIT]   = bus_flag;
    end

    always_comb
    begin
        data_d  = data_q;
        valid_d = rd_in.strobe;
        if (rd_in.strobe)
        begin
            case (rd_in.addr)
                SIS_ADDR_MAKER:  data_d = MAKER_CODE;
                SIS_ADDR_PART:   data_d = {DIE_REV, PART_CODE};
                SIS_ADDR_CAPS:   data_d = SIS_CAPS_VALUE;
                SIS_ADDR_STATUS: data_d = {8'h00, status_now};
                default:         data_d = SIS_DATA_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            data_q   <= SIS_DATA_RESET;
            valid_q  <= 1'b0;
            unread_q <= 1'b0;
            status_q <= SIS_STATUS_RESET;
        end
        else
        begin
            data_q   <= data_d;
            valid_q  <= valid_d;
            unread_q <= unread_d;
            status_q <= status_now;
        end
    end

    assign rd_data_out  = data_q;
    assign rd_valid_out = valid_q;
    assign status_out   = status_q;

    property p_status_read_value;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_status |=> rd_data_out == {8'h00, $past(status_now)};
    endproperty
    a_status_read_value: assert property (p_status_read_value)
        else $error("status read returned wrong value");

    property p_bus_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_status && !ev_in.nack_seen |=> !bus_flag;
    endproperty
    a_bus_clear: assert property (p_bus_clear)
        else $error("bus flag not cleared by status read");

    property p_bus_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_in.nack_seen |=> bus_flag;
    endproperty
    a_bus_set: assert property (p_bus_set)
        else $error("bus flag not set by nack");

    property p_event_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_in.result_stored |=> ev_flag ##1 status_out[0];
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("event flag not set");

    property p_event_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_flag && !ev_in.func_handled && !rd_readout |=> ev_flag;
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event flag dropped without clear");

    property p_overrun;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_in.result_stored ##1 (ev_in.result_stored && !rd_readout)
        |=> err_flag;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun did not set error flag");

    property p_readout_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_readout && !ev_in.result_stored && !ev_in.func_error
        |=> !ev_flag && !err_flag;
    endproperty
    a_readout_clear: assert property (p_readout_clear)
        else $error("readout read did not clear flags");

    property p_error_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_in.func_error |=> err_flag;
    endproperty
    a_error_set: assert property (p_error_set)
        else $error("error flag not set");

    property p_error_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        ev_in.func_handled && !ev_in.func_error && !overrun |=> !err_flag;
    endproperty
    a_error_clear: assert property (p_error_clear)
        else $error("error flag not cleared when handled");

    property p_zero_bits;
        @(posedge clk_in) disable iff (!rst_n_in)
        status_out[3:1] == 3'h0 && status_out[6:5] == 2'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("unused status bits not zero");

    property p_reset_clears;
        @(posedge clk_in)
        !rst_n_in |=> status_out == SIS_STATUS_RESET && !bus_flag;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset did not clear status");

endmodule : sis_regs

// ===== bench/sis_master.sv
// Bus master model that issues register reads and device reset.
// Assumes the bench sets its requests at the falling clock edge.
`timescale 1ns/1ps
module sis_master
    import sis_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [5:0] addr_in,
    input  wire logic       rst_req_in,
    output sis_read_t       rd_out,
    output logic            rst_n_out
);
    logic [5:0] idle_q = 6'h15;
    // An idle address bus keeps changing, so a stale address never helps.
    always @(posedge clk_in)
        idle_q <= idle_q + 6'h25;
    always_comb
    begin
        rd_out.strobe = go_in;
        rd_out.addr   = go_in ? addr_in : idle_q;
        rst_n_out     = ~rst_req_in;
    end
endmodule : sis_master

// ===== bench/testbench.sv
// Self-checking bench for the identification and status registers.
// Assumes the master model drives reads and reset on the falling edge.
`timescale 1ns/1ps
module testbench
    import sis_pkg::*;
;
    localparam logic [15:0] MAKER = 16'h3C3C; // Arbitrary value.
    localparam logic [10:0] PART  = 11'h123;  // Arbitrary value.
    localparam logic [4:0]  REV   = 5'h07;    // Arbitrary value.
    localparam logic [9:0]  SEQ [12] = '{10'h044, 10'h004, 10'h004,
        10'h200, 10'h204, 10'h004, 10'h284, 10'h009, 10'h004, 10'h104,
        10'h084, 10'h004};
    logic        clk_in = 1'b0;
    logic        go = 1'b0;
    logic        rst_req = 1'b1;
    logic [5:0]  addr = 6'h00;
    sis_events_t ev = '0;
    sis_read_t   rd;
    logic        rst_n;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [7:0]  status;
    logic [7:0]  s1, s2, fl;
    logic        unread, pv;
    logic [15:0] pd;
    int          bad_count = 0;
    int          compares = 0;

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    sis_master u_master (.clk_in(clk_in), .go_in(go), .addr_in(addr),
        .rst_req_in(rst_req), .rd_out(rd), .rst_n_out(rst_n));
    sis_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .DIE_REV(REV)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n), .rd_in(rd), .ev_in(ev),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .status_out(status));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    function automatic logic [15:0] exp_rd(logic [5:0] a, logic [7:0] st);
        case (a)
            SIS_ADDR_MAKER:  return MAKER;
            SIS_ADDR_PART:   return {REV, PART};
            SIS_ADDR_CAPS:   return 16'h0001;
            SIS_ADDR_STATUS: return {8'h00, st};
            default:         return 16'h0000;
        endcase
    endfunction : exp_rd

    task automatic step(input sis_events_t e, input logic g,
                        input logic [5:0] a);
        logic rdo;
        logic rds;
        @(negedge clk_in);
        check({15'h0, rd_valid}, {15'h0, pv});
        if (pv)
            check(rd_data, pd);
        check({8'h00, status}, {8'h00, s2});
        ev = e;
        go = g;
        addr = a;
        rdo = g && a == SIS_ADDR_READOUT;
        rds = g && a == SIS_ADDR_STATUS;
        pv = g;
        pd = exp_rd(a, fl);
        s2 = s1;
        fl[7] = e.nack_seen | (fl[7] & ~rds);
        fl[4] = e.func_error | (e.result_stored & unread & ~rdo)
              | (fl[4] & ~e.func_handled & ~rdo);
        fl[0] = e.result_stored | (fl[0] & ~e.func_handled & ~rdo);
        unread = e.result_stored | (unread & ~rdo);
        s1 = fl;
    endtask : step

    task automatic do_reset();
        @(negedge clk_in);
        rst_req = 1'b1;
        go = 1'b0;
        ev = '0;
        repeat (20) @(negedge clk_in);
        rst_req = 1'b0;
        fl = '0;
        s1 = '0;
        s2 = '0;
        unread = 1'b0;
        pv = 1'b0;
    endtask : do_reset

    task automatic rand_run(input int n);
        for (int i = 0; i < n; i++)
            step(4'($urandom) & 4'($urandom) & 4'($urandom),
                 1'($urandom), 6'($urandom % 12));
    endtask : rand_run

    initial
    begin
        void'($urandom(32'h72CA0E96));
        do_reset();
        for (int i = 0; i < 8; i++)
            step('0, 1'b1, 6'(i));
        // Corner cases: events racing reads, overrun, clears.
        foreach (SEQ[i])
            step(SEQ[i][9:6], 1'b1, SEQ[i][5:0]);
        rand_run(3000);
        do_reset();
        rand_run(1000);
        step('0, 1'b0, 6'h00);
        final_report();
    end

    initial
    begin
        #100us;
        bad_count++;
        final_report();
    end
endmodule : testbench
